// *** design/ipps_top.sv ***
// Peripheral input route selection: twelve route registers and muxes.
// Assumes synchronous pins, a plain register port and two resets.
//
// Operation
// R1: Bits 2:0 of a route register pick pin 0 to 7 of the chosen port.
// R2: Bits 4:3 pick port A, B or C, code 11 is reserved, bits 7:5 read zero.
// R3: Twelve inputs are routable, each only from its two permitted ports.
// R4: After power-on each input is routed to its fixed default pin.
// R5: Power-on or brown-out reset loads the default codes; other resets keep them.
module ipps_top (
    input wire logic mclk,                              // System clock
    input wire logic rst,                               // Power-on/brown-out reset
    input wire logic soft_rst,                          // Other resets, sync
    input wire logic [ipps_pkg::ADDR_W-1:0] addr,       // Register address
    input wire logic [ipps_pkg::DATA_W-1:0] wdata,      // Write data
    input wire logic wr,                                // Write strobe
    input wire logic rd,                                // Read strobe
    output logic [ipps_pkg::DATA_W-1:0] rdata,          // Read data
    input wire logic [7:0] port_a_in,                   // Port A pins
    input wire logic [7:0] port_b_in,                   // Port B pins
    input wire logic [7:0] port_c_in,                   // Port C pins
    output logic ext_irq0_in,                           // Interrupt 0 input
    output logic ext_irq1_in,                           // Interrupt 1 input
    output logic ext_irq2_in,                           // Interrupt 2 input
    output logic timer0_clock_in,                       // Timer0 clock
    output logic timer1_clock_in,                       // Timer1 clock
    output logic timer1_gate_in,                        // Timer1 gate
    output logic timer3_clock_in,                       // Timer3 clock
    output logic timer3_gate_in,                        // Timer3 gate
    output logic timer5_clock_in,                       // Timer5 clock
    output logic timer5_gate_in,                        // Timer5 gate
    output logic timer2_clock_in,                       // Timer2 clock
    output logic timer4_clock_in                        // Timer4 clock
);

    // ****************************************
    // Route state and decode
    // ****************************************
    logic [ipps_pkg::CODE_W-1:0] route_r [ipps_pkg::NUM_ROUTES];
    logic [ipps_pkg::CODE_W-1:0] route_nxt [ipps_pkg::NUM_ROUTES];
    logic [ipps_pkg::NUM_ROUTES-1:0] wr_hit;
    logic level [ipps_pkg::NUM_ROUTES];
    logic level_r [ipps_pkg::NUM_ROUTES];
    logic [ipps_pkg::CODE_W-1:0] rd_code;
    logic [ipps_pkg::DATA_W-1:0] rdata_r;
    logic [ipps_pkg::DATA_W-1:0] rdata_nxt;

    // ****************************************
    // Write decode
    // ****************************************
    // Unmapped indices select nothing, so the write is dropped
    always_comb begin
        wr_hit = '0;
        case (addr)
            ipps_pkg::EXT_IRQ0_ROUTE: begin
                wr_hit[ipps_pkg::EXT_IRQ0_ROUTE] = wr;
            end
            ipps_pkg::EXT_IRQ1_ROUTE: begin
                wr_hit[ipps_pkg::EXT_IRQ1_ROUTE] = wr;
            end
            ipps_pkg::EXT_IRQ2_ROUTE: begin
                wr_hit[ipps_pkg::EXT_IRQ2_ROUTE] = wr;
            end
            ipps_pkg::TIMER0_CLOCK_ROUTE: begin
                wr_hit[ipps_pkg::TIMER0_CLOCK_ROUTE] = wr;
            end
            ipps_pkg::TIMER1_CLOCK_ROUTE: begin
                wr_hit[ipps_pkg::TIMER1_CLOCK_ROUTE] = wr;
            end
            ipps_pkg::TIMER1_GATE_ROUTE: begin
                wr_hit[ipps_pkg::TIMER1_GATE_ROUTE] = wr;
            end
            ipps_pkg::TIMER3_CLOCK_ROUTE: begin
                wr_hit[ipps_pkg::TIMER3_CLOCK_ROUTE] = wr;
            end
            ipps_pkg::TIMER3_GATE_ROUTE: begin
                wr_hit[ipps_pkg::TIMER3_GATE_ROUTE] = wr;
            end
            ipps_pkg::TIMER5_CLOCK_ROUTE: begin
                wr_hit[ipps_pkg::TIMER5_CLOCK_ROUTE] = wr;
            end
            ipps_pkg::TIMER5_GATE_ROUTE: begin
                wr_hit[ipps_pkg::TIMER5_GATE_ROUTE] = wr;
            end
            ipps_pkg::TIMER2_CLOCK_ROUTE: begin
                wr_hit[ipps_pkg::TIMER2_CLOCK_ROUTE] = wr;
            end
            ipps_pkg::TIMER4_CLOCK_ROUTE: begin
                wr_hit[ipps_pkg::TIMER4_CLOCK_ROUTE] = wr;
            end
            default: begin
                wr_hit = '0;
            end
        endcase
    end

    // ****************************************
    // Per-route registers and muxes
    // ****************************************
    for (genvar i = 0; i < ipps_pkg::NUM_ROUTES; i++) begin : g_route
        always_comb begin
            route_nxt[i] = route_r[i];
            if (wr_hit[i]) begin
                route_nxt[i] = wdata[ipps_pkg::CODE_W-1:0];  // [R1] [R2]
            end
        end

        // Only power-on or brown-out reset reloads the default code
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                route_r[i] <= ipps_pkg::DEFAULT_CODE[i];  // [R4] [R5]
            end else begin
                route_r[i] <= route_nxt[i];  // [R5]
            end
        end

        // Disallowed ports and the reserved code give a low level
        ipps_route_mux ipps_route_mux_inst (
            .code(route_r[i]),
            .allow(ipps_pkg::PORT_ALLOW[i]),  // [R3]
            .port_a_in(port_a_in),
            .port_b_in(port_b_in),
            .port_c_in(port_c_in),
            .level(level[i])
        );

        // Routed level lags the pins by one clock
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                level_r[i] <= 1'b0;
            end else begin
                level_r[i] <= level[i];
            end
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    // Unmapped indices read as zero
    always_comb begin
        rd_code = '0;
        case (addr)
            ipps_pkg::EXT_IRQ0_ROUTE: begin
                rd_code = route_r[ipps_pkg::EXT_IRQ0_ROUTE];
            end
            ipps_pkg::EXT_IRQ1_ROUTE: begin
                rd_code = route_r[ipps_pkg::EXT_IRQ1_ROUTE];
            end
            ipps_pkg::EXT_IRQ2_ROUTE: begin
                rd_code = route_r[ipps_pkg::EXT_IRQ2_ROUTE];
            end
            ipps_pkg::TIMER0_CLOCK_ROUTE: begin
                rd_code = route_r[ipps_pkg::TIMER0_CLOCK_ROUTE];
            end
            ipps_pkg::TIMER1_CLOCK_ROUTE: begin
                rd_code = route_r[ipps_pkg::TIMER1_CLOCK_ROUTE];
            end
            ipps_pkg::TIMER1_GATE_ROUTE: begin
                rd_code = route_r[ipps_pkg::TIMER1_GATE_ROUTE];
            end
            ipps_pkg::TIMER3_CLOCK_ROUTE: begin
                rd_code = route_r[ipps_pkg::TIMER3_CLOCK_ROUTE];
            end
            ipps_pkg::TIMER3_GATE_ROUTE: begin
                rd_code = route_r[ipps_pkg::TIMER3_GATE_ROUTE];
            end
            ipps_pkg::TIMER5_CLOCK_ROUTE: begin
                rd_code = route_r[ipps_pkg::TIMER5_CLOCK_ROUTE];
            end
            ipps_pkg::TIMER5_GATE_ROUTE: begin
                rd_code = route_r[ipps_pkg::TIMER5_GATE_ROUTE];
            end
            ipps_pkg::TIMER2_CLOCK_ROUTE: begin
                rd_code = route_r[ipps_pkg::TIMER2_CLOCK_ROUTE];
            end
            ipps_pkg::TIMER4_CLOCK_ROUTE: begin
                rd_code = route_r[ipps_pkg::TIMER4_CLOCK_ROUTE];
            end
            default: begin
                rd_code = '0;
            end
        endcase
    end

    // Data stand one cycle after a strobe while soft_rst is low, zero otherwise
    always_comb begin
        rdata_nxt = '0;
        if (rd && !soft_rst) begin
            rdata_nxt[ipps_pkg::CODE_W-1:0] = rd_code;  // [R2]
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;

    // ****************************************
    // Routed outputs
    // ****************************************
    // Index order follows the register map
    assign ext_irq0_in = level_r[ipps_pkg::EXT_IRQ0_ROUTE];
    assign ext_irq1_in = level_r[ipps_pkg::EXT_IRQ1_ROUTE];
    assign ext_irq2_in = level_r[ipps_pkg::EXT_IRQ2_ROUTE];
    assign timer0_clock_in = level_r[ipps_pkg::TIMER0_CLOCK_ROUTE];
    assign timer1_clock_in = level_r[ipps_pkg::TIMER1_CLOCK_ROUTE];
    assign timer1_gate_in = level_r[ipps_pkg::TIMER1_GATE_ROUTE];
    assign timer3_clock_in = level_r[ipps_pkg::TIMER3_CLOCK_ROUTE];
    assign timer3_gate_in = level_r[ipps_pkg::TIMER3_GATE_ROUTE];
    assign timer5_clock_in = level_r[ipps_pkg::TIMER5_CLOCK_ROUTE];
    assign timer5_gate_in = level_r[ipps_pkg::TIMER5_GATE_ROUTE];
    assign timer2_clock_in = level_r[ipps_pkg::TIMER2_CLOCK_ROUTE];
    assign timer4_clock_in = level_r[ipps_pkg::TIMER4_CLOCK_ROUTE];

endmodule

// *** design/ipps_pkg.sv ***
// Package for the peripheral input route selection block.
// Assumes a single 20 MHz clock domain and a plain register port.
package ipps_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_ROUTES = 12;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CODE_W = 5;
    localparam int PIN_W = 3;
    localparam int PORT_W = 2;
    localparam int PINS_PER_PORT = 8;

    // ****************************************
    // Field layout
    // ****************************************
    localparam int PIN_LSB = 0;
    localparam int PORT_LSB = 3;

    // Port codes in bits 4:3
    localparam logic [PORT_W-1:0] PORT_A = 2'h0;
    localparam logic [PORT_W-1:0] PORT_B = 2'h1;
    localparam logic [PORT_W-1:0] PORT_C = 2'h2;
    localparam logic [PORT_W-1:0] PORT_RSVD = 2'h3;

    // ****************************************
    // Register indices (register addresses)
    // ****************************************
    localparam logic [ADDR_W-1:0] EXT_IRQ0_ROUTE = 4'h0;
    localparam logic [ADDR_W-1:0] EXT_IRQ1_ROUTE = 4'h1;
    localparam logic [ADDR_W-1:0] EXT_IRQ2_ROUTE = 4'h2;
    localparam logic [ADDR_W-1:0] TIMER0_CLOCK_ROUTE = 4'h3;
    localparam logic [ADDR_W-1:0] TIMER1_CLOCK_ROUTE = 4'h4;
    localparam logic [ADDR_W-1:0] TIMER1_GATE_ROUTE = 4'h5;
    localparam logic [ADDR_W-1:0] TIMER3_CLOCK_ROUTE = 4'h6;
    localparam logic [ADDR_W-1:0] TIMER3_GATE_ROUTE = 4'h7;
    localparam logic [ADDR_W-1:0] TIMER5_CLOCK_ROUTE = 4'h8;
    localparam logic [ADDR_W-1:0] TIMER5_GATE_ROUTE = 4'h9;
    localparam logic [ADDR_W-1:0] TIMER2_CLOCK_ROUTE = 4'hA;
    localparam logic [ADDR_W-1:0] TIMER4_CLOCK_ROUTE = 4'hB;

    // ****************************************
    // Power-on default codes, index order
    // ****************************************
    localparam logic [CODE_W-1:0] DEFAULT_CODE [NUM_ROUTES] = '{
        5'h08, 5'h09, 5'h0A, 5'h04, 5'h10, 5'h0D,
        5'h10, 5'h10, 5'h12, 5'h0C, 5'h13, 5'h15
    };

    // Allowed ports per input: bit0 A, bit1 B, bit2 C
    localparam logic [2:0] PORT_ALLOW [NUM_ROUTES] = '{
        3'h3, 3'h3, 3'h3, 3'h3, 3'h5, 3'h6,
        3'h6, 3'h5, 3'h5, 3'h6, 3'h5, 3'h6
    };

endpackage

// *** design/ipps_route_mux.sv ***
// One routed input: picks a pin level from the port buses.
// Assumes the pin levels are already synchronous to mclk.
module ipps_route_mux (
    input wire logic [ipps_pkg::CODE_W-1:0] code,   // Route code
    input wire logic [2:0] allow,                   // Allowed ports mask
    input wire logic [7:0] port_a_in,               // Port A pin levels
    input wire logic [7:0] port_b_in,               // Port B pin levels
    input wire logic [7:0] port_c_in,               // Port C pin levels
    output logic level                              // Routed level
);

    logic [ipps_pkg::PORT_W-1:0] port_sel;
    logic [ipps_pkg::PIN_W-1:0] pin_sel;

    assign port_sel = code[ipps_pkg::PORT_LSB +: ipps_pkg::PORT_W];
    assign pin_sel = code[ipps_pkg::PIN_LSB +: ipps_pkg::PIN_W];

    always_comb begin
        level = 1'b0;
        case (port_sel)
            ipps_pkg::PORT_A: if (allow[0]) level = port_a_in[pin_sel];  // [R1] [R3]
            ipps_pkg::PORT_B: if (allow[1]) level = port_b_in[pin_sel];  // [R1] [R3]
            ipps_pkg::PORT_C: if (allow[2]) level = port_c_in[pin_sel];  // [R1] [R3]
            default: level = 1'b0;  // [R2]
        endcase
    end

endmodule

// *** test/ipps_pins.sv ***
// Pin model: ports C, B, A as one changing pattern.
// Assumes hold stalls the pins like a slow source.
module ipps_pins (
    input wire logic mclk, // Clock
    input wire logic rst, // Reset
    input wire logic hold, // Stall
    output logic [23:0] pins // Pins
);
    always_ff @(posedge mclk or posedge rst)
        pins <= rst ? 24'h5A3C01 : hold ? pins : {pins[22:0], ^pins[23:21]};
endmodule

// *** test/ipps_top_asserts.sv ***
// Checker: shadows route 0 and its level.
// Assumes the top module's ports, bound below.
module ipps_top_asserts (
    input wire logic mclk, // Clock
    input wire logic rst, // Reset
    input wire logic [3:0] addr, // Addr
    input wire logic [7:0] wdata, // Data
    input wire logic wr, // Write
    input wire logic [7:0] port_a_in, // Port A
    input wire logic [7:0] port_b_in, // Port B
    input wire logic ext_irq0_in // Route 0
);
    logic [4:0] c_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    always_ff @(posedge mclk or posedge rst)
        c_r <= rst ? 5'h08 : (wr && addr == 4'h0) ? wdata[4:0] : c_r;
    AST_ROUTE: assert property (!$past(rst) |-> ext_irq0_in == $past(!c_r[4] &&
        (c_r[3] ? port_b_in[c_r[2:0]] : port_a_in[c_r[2:0]]))) else $error("Bad level");
    AST_PORT_C: assert property ($past(!rst && c_r[4:3] == 2'h2) |-> !ext_irq0_in)
        else $error("Port C routed");
    AST_RSVD: assert property ($past(!rst && c_r[4:3] == 2'h3) |-> !ext_irq0_in)
        else $error("Reserved routed");
    AST_DEF: assert property ($past(!rst && c_r == 5'h08)
        |-> ext_irq0_in == $past(port_b_in[0])) else $error("Default level");
    AST_POR: assert property ($fell(rst) |-> ##2 ext_irq0_in == $past(port_b_in[0]))
        else $error("Reset route");
endmodule
bind ipps_top ipps_top_asserts chk_inst (.mclk, .rst, .addr, .wdata, .wr,
    .port_a_in, .port_b_in, .ext_irq0_in);

// *** test/tb_ipps_top.sv ***
// Bench: bus tasks, read-back and routed-level checks.
// Assumes the pin model and the bound checker.
module tb_ipps_top;
    timeunit 1ns / 1ns;
    logic mclk = 1'b0, rst = 1'b1, soft_rst = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic [23:0] pins;
    logic [11:0] outs;
    logic [4:0] code [13];
    int errors = 0, total_checks = 0;
    always #25 mclk = ~mclk;
    always @(posedge mclk) soft_rst <= wr && addr == 4'hC;
    ipps_pins ipps_pins_inst (.mclk, .rst, .hold(rd), .pins);
    ipps_top ipps_top_inst (.mclk, .rst, .soft_rst, .addr, .wdata, .wr, .rd, .rdata,
        .port_a_in(pins[7:0]), .port_b_in(pins[15:8]), .port_c_in(pins[23:16]),
        .ext_irq0_in(outs[0]), .ext_irq1_in(outs[1]), .ext_irq2_in(outs[2]),
        .timer0_clock_in(outs[3]), .timer1_clock_in(outs[4]), .timer1_gate_in(outs[5]),
        .timer3_clock_in(outs[6]), .timer3_gate_in(outs[7]), .timer5_clock_in(outs[8]),
        .timer5_gate_in(outs[9]), .timer2_clock_in(outs[10]), .timer4_clock_in(outs[11]));
    task automatic check(logic [7:0] seen, logic [7:0] exp);
        total_checks++;
        errors += int'(seen !== exp);
        if (seen !== exp) $display("CHECK FAILED at %0t: %h not %h", $time, seen, exp);
    endtask
    task automatic xfer(logic w, int a, logic [7:0] d);
        @(posedge mclk);
        addr <= 4'(a);
        wdata <= d;
        {wr, rd} <= {w, !w};
        @(posedge mclk);
        {wr, rd} <= 2'h0;
        if (w && a < 12) code[a] = d[4:0];
    endtask
    task automatic reg_chk(int i);
        logic e;
        xfer(1'b0, i, 8'h00);
        @(negedge mclk);
        check(rdata, {3'h0, code[i]});
        e = code[i][4:3] != 2'h3 && ipps_pkg::PORT_ALLOW[i % 12][code[i][4:3]] && pins[code[i]];
        @(negedge mclk);
        if (i < 12) check({7'h00, outs[i % 12]}, {7'h00, e});
    endtask
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        foreach (code[i]) code[i] = i < 12 ? ipps_pkg::DEFAULT_CODE[i % 12] : 5'h00;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            for (int i = 0; i < 13; i++) reg_chk(i);
            $display("Test round %0d done", k);
            for (int i = 0; i < 13; i++) xfer(1'b1, i, {3'h7, k[1:0], 3'(i + k)});
        end
        // Power-on reset in mid-run must bring back every default code
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        foreach (code[i]) code[i] = i < 12 ? ipps_pkg::DEFAULT_CODE[i % 12] : 5'h00;
        for (int i = 0; i < 13; i++) reg_chk(i);
        $display("Reset reload test done");
        close_out();
    end
endmodule
